/* File: common/cbl_pkg.sv */
// Shared constants and types for the branch-to-link-register executor
package cbl_pkg;
	// Instruction field positions, bit 0 of the word is the LSB here
	localparam int unsigned OP_LSB = 26;
	localparam int unsigned BO_LSB = 21;
	localparam int unsigned BI_LSB = 16;
	localparam int unsigned BH_LSB = 11;
	localparam int unsigned XO_LSB = 1;
	localparam int unsigned LK_POS = 0;
	localparam logic [5:0] CBL_PRIMARY_OP = 6'h13;
	localparam logic [9:0] CBL_EXT_OP     = 10'h010;
	// Branch option bit roles inside the five-bit field
	localparam int unsigned BO_NOCOND = 4;
	localparam int unsigned BO_SENSE  = 3;
	localparam int unsigned BO_NODEC  = 2;
	localparam int unsigned BO_ZERO   = 1;
	localparam int unsigned BO_HINT   = 0;
	localparam logic [31:0] CBL_INSN_BYTES = 32'h0000_0004;
	// Register byte offsets on the bus
	localparam logic [7:0] ADDR_LR     = 8'h00;
	localparam logic [7:0] ADDR_CTR    = 8'h04;
	localparam logic [7:0] ADDR_CR     = 8'h08;
	localparam logic [7:0] ADDR_MODE   = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_TARGET = 8'h14;
	localparam logic [7:0] ADDR_NEXT   = 8'h18;
	localparam logic [31:0] LR_RST  = 32'h0000_0000;
	localparam logic [31:0] CTR_RST = 32'h0000_0000;
	localparam logic [31:0] CR_RST  = 32'h0000_0000;
	typedef enum logic [1:0] {
		CBL_MODE_LEGACY  = 2'h0,
		CBL_MODE_CLASSIC = 2'h1,
		CBL_MODE_V2      = 2'h2
	} cbl_mode_e;
	localparam cbl_mode_e MODE_RST = CBL_MODE_V2;
	typedef enum logic [1:0] {
		CBL_AT_NONE  = 2'h0,
		CBL_AT_RSVD  = 2'h1,
		CBL_AT_NOT   = 2'h2,
		CBL_AT_TAKEN = 2'h3
	} cbl_at_e;
	typedef enum logic [1:0] {
		CBL_BH_REPEAT = 2'h0,
		CBL_BH_RSVD1  = 2'h1,
		CBL_BH_RSVD2  = 2'h2,
		CBL_BH_UNPRED = 2'h3
	} cbl_bh_e;
	// Low bits of the status register, LSB last
	typedef struct packed {
		cbl_bh_e   bh;
		cbl_at_e   at;
		logic      y_hint;
		logic      decr;
		logic      linked;
		logic      unrec;
		logic      invalid;
		logic      taken;
		logic      valid;
	} cbl_flags_s;
	typedef struct packed {
		cbl_flags_s  flags;
		logic [31:0] target;
		logic [31:0] next;
	} cbl_result_s;
	typedef struct packed {
		logic        valid;
		logic [31:0] insn;
		logic [31:0] cia;
	} cbl_fetch_s;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} cbl_wb_req_s;
endpackage

/* File: design/cbl_exec.sv */
// Conditional branch-to-link-register executor with a Wishbone register file
module cbl_exec
	import cbl_pkg::*;
(
	input  wire logic        clk_i,      // 10 MHz core clock
	input  wire logic        rst_i,      // Synchronous reset, active high
	input  wire cbl_fetch_s  fetch_i,    // Instruction offered by sequencing
	input  wire cbl_wb_req_s wb_i,       // Wishbone request
	output logic             wb_ack_o,   // Wishbone acknowledge
	output logic [31:0]      wb_dat_o,   // Wishbone read data
	output cbl_result_s      res_o,      // Branch outcome, one cycle after offer
	output logic [31:0]      lr_o,       // Current link register
	output logic [31:0]      ctr_o       // Current loop count register
);
	typedef struct packed {
		logic [31:0] lr;
		logic [31:0] ctr;
		logic [31:0] cr;
		cbl_mode_e   mode;
		cbl_result_s res;
		logic        ack;
		logic [31:0] rdat;
	} cbl_state_s;

	localparam cbl_state_s STATE_RST = '{
		lr: LR_RST, ctr: CTR_RST, cr: CR_RST, mode: MODE_RST,
		res: '0, ack: 1'b0, rdat: 32'h0000_0000
	};

	cbl_state_s st_q;
	cbl_state_s st_d;

	function automatic logic [31:0] merge_be(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Positions that must be zero differ between the two newer encodings
	function automatic logic z_violation(input logic [4:0] bo, input cbl_mode_e mode);
		logic v;
		v = 1'b0;
		unique case (mode)
			CBL_MODE_LEGACY: begin
				v = 1'b0;
			end
			CBL_MODE_CLASSIC: begin
				unique case ({bo[BO_NOCOND], bo[BO_NODEC]})
					2'b00: v = 1'b0;
					2'b01: v = bo[BO_ZERO];
					2'b10: v = bo[BO_SENSE];
					2'b11: v = bo[BO_SENSE] | bo[BO_ZERO] | bo[BO_HINT];
				endcase
			end
			default: begin
				unique case ({bo[BO_NOCOND], bo[BO_NODEC]})
					2'b00: v = bo[BO_HINT];
					2'b01: v = 1'b0;
					2'b10: v = 1'b0;
					2'b11: v = bo[BO_SENSE] | bo[BO_ZERO] | bo[BO_HINT];
				endcase
			end
		endcase
		return v;
	endfunction

	// Code 3 is not given a name and behaves as the newer encoding
	function automatic logic is_v2(input cbl_mode_e mode);
		return mode == CBL_MODE_V2 || mode == cbl_mode_e'(2'h3);
	endfunction

	function automatic cbl_at_e at_of(input logic [4:0] bo);
		cbl_at_e h;
		h = CBL_AT_NONE;
		if (!bo[BO_NOCOND] && bo[BO_NODEC]) begin
			h = cbl_at_e'(bo[1:0]);
		end else if (bo[BO_NOCOND] && !bo[BO_NODEC]) begin
			h = cbl_at_e'({bo[BO_SENSE], bo[BO_HINT]});
		end
		return h;
	endfunction

	logic [5:0]  f_op;
	logic [4:0]  f_bo;
	logic [4:0]  f_bi;
	logic [1:0]  f_bh;
	logic [9:0]  f_xo;
	logic        f_lk;
	logic        hit;
	logic        bad;
	logic        go;
	logic [31:0] ctr_dec;
	logic        cr_bit;
	logic        ctr_ok;
	logic        cond_ok;
	logic        bus_req;
	logic        bus_wr;
	logic [31:0] cia_next;

	assign f_op = fetch_i.insn[OP_LSB +: 6];
	assign f_bo = fetch_i.insn[BO_LSB +: 5];
	assign f_bi = fetch_i.insn[BI_LSB +: 5];
	assign f_bh = fetch_i.insn[BH_LSB +: 2];
	assign f_xo = fetch_i.insn[XO_LSB +: 10];
	assign f_lk = fetch_i.insn[LK_POS];
	assign hit = fetch_i.valid && f_op == CBL_PRIMARY_OP && f_xo == CBL_EXT_OP;
	assign bad = z_violation(f_bo, st_q.mode);
	assign go = hit && !bad;
	assign ctr_dec = st_q.ctr - 32'h0000_0001;
	// Condition register bit 0 is the most significant bit
	assign cr_bit = st_q.cr[5'd31 - f_bi];
	// Patterns 0000y/0001y/0100y/0101y/1z00y/1z01y test the decremented count
	assign ctr_ok = f_bo[BO_NODEC] | ((ctr_dec != 32'h0000_0000) ^ f_bo[BO_ZERO]);
	// Sense bit picks true or false; 1z1zz and 1z0 forms skip it
	assign cond_ok = f_bo[BO_NOCOND] | (cr_bit == f_bo[BO_SENSE]);
	assign bus_req = wb_i.cyc && wb_i.stb && !st_q.ack;
	assign bus_wr = bus_req && wb_i.we;
	assign cia_next = fetch_i.cia + CBL_INSN_BYTES;

	always_comb begin
		st_d = st_q;
		st_d.ack = 1'b0;
		st_d.res.flags.valid = 1'b0;
		if (bus_req) begin
			st_d.ack = 1'b1;
			unique case (wb_i.adr)
				ADDR_LR:     st_d.rdat = st_q.lr;
				ADDR_CTR:    st_d.rdat = st_q.ctr;
				ADDR_CR:     st_d.rdat = st_q.cr;
				ADDR_MODE:   st_d.rdat = {30'h0000_0000, st_q.mode};
				ADDR_STATUS: st_d.rdat = {21'h00_0000, st_q.res.flags};
				ADDR_TARGET: st_d.rdat = st_q.res.target;
				ADDR_NEXT:   st_d.rdat = st_q.res.next;
				default:     st_d.rdat = 32'h0000_0000;
			endcase
			if (bus_wr) begin
				unique case (wb_i.adr)
					ADDR_LR:   st_d.lr = merge_be(st_q.lr, wb_i.dat, wb_i.sel);
					ADDR_CTR:  st_d.ctr = merge_be(st_q.ctr, wb_i.dat, wb_i.sel);
					ADDR_CR:   st_d.cr = merge_be(st_q.cr, wb_i.dat, wb_i.sel);
					ADDR_MODE: begin
						if (wb_i.sel[0]) begin
							st_d.mode = cbl_mode_e'(wb_i.dat[1:0]);
						end
					end
					default: ;
				endcase
			end
		end
		// A linking instruction overrides a software write of LR, a decrementing one of CTR, in the same cycle
		if (fetch_i.valid) begin
			st_d.res.flags.valid = 1'b1;
			st_d.res.flags.unrec = !hit;
			st_d.res.flags.invalid = hit && bad;
			st_d.res.flags.taken = go && ctr_ok && cond_ok;
			st_d.res.flags.decr = go && !f_bo[BO_NODEC];
			st_d.res.flags.linked = go && f_lk;
			// Hint carried out as is; branching never depends on it
			st_d.res.flags.y_hint = hit && !is_v2(st_q.mode) && f_bo[BO_HINT];
			st_d.res.flags.at = (hit && is_v2(st_q.mode)) ? at_of(f_bo) : CBL_AT_NONE;
			st_d.res.flags.bh = hit ? cbl_bh_e'(f_bh) : CBL_BH_REPEAT;
			st_d.res.target = {st_q.lr[31:2], 2'b00};
			st_d.res.next = (go && ctr_ok && cond_ok) ? {st_q.lr[31:2], 2'b00} : cia_next;
			if (go && !f_bo[BO_NODEC]) begin
				st_d.ctr = ctr_dec;
			end
			if (go && f_lk) begin
				st_d.lr = cia_next;
			end
			// Condition register is never written here, nor is any exception state
			st_d.cr = st_d.cr;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= STATE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign wb_ack_o = st_q.ack;
	assign wb_dat_o = st_q.rdat;
	assign res_o = st_q.res;
	assign lr_o = st_q.lr;
	assign ctr_o = st_q.ctr;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	target_from_link_a: assert property (
		hit |=> res_o.target == {$past(st_q.lr[31:2]), 2'b00} && res_o.flags.valid)
		else $error("Branch target not taken from link register");

	link_write_a: assert property (
		go && f_lk |=> st_q.lr == $past(fetch_i.cia) + CBL_INSN_BYTES)
		else $error("Return address not written to link register");

	cr_untouched_a: assert property (
		fetch_i.valid && !(bus_wr && wb_i.adr == ADDR_CR) |=> $stable(st_q.cr))
		else $error("Condition register changed by branch");

	ctr_decrement_a: assert property (
		go && !f_bo[BO_NODEC] |=> st_q.ctr == $past(st_q.ctr) - 32'h0000_0001)
		else $error("Loop count not decremented by one");

	ctr_kept_a: assert property (
		go && f_bo[BO_NODEC] && !(bus_wr && wb_i.adr == ADDR_CTR) |=> $stable(st_q.ctr))
		else $error("Loop count altered by a no-decrement form");

	cond_branch_a: assert property (
		go && !f_bo[BO_NOCOND] && f_bo[BO_NODEC]
		|=> res_o.flags.taken == ($past(cr_bit) == $past(f_bo[BO_SENSE])))
		else $error("Condition-only branch decided wrongly");

	zero_branch_a: assert property (
		go && f_bo[4:1] == 4'h5 && st_q.ctr == 32'h0000_0001 && cr_bit
		|=> res_o.flags.taken && res_o.next == res_o.target)
		else $error("Count-zero true branch not taken");

	invalid_form_a: assert property (
		hit && st_q.mode == CBL_MODE_V2 && !f_bo[BO_NOCOND] && !f_bo[BO_NODEC] && f_bo[BO_HINT]
		|=> res_o.flags.invalid && !res_o.flags.taken && $stable(st_q.ctr))
		else $error("Set z bit not flagged as invalid form");

	legacy_accept_a: assert property (
		hit && st_q.mode == CBL_MODE_LEGACY |=> !res_o.flags.invalid)
		else $error("Legacy mode rejected a form");

	at_hint_a: assert property (
		hit && st_q.mode == CBL_MODE_V2 && !f_bo[BO_NOCOND] && f_bo[BO_NODEC]
		|=> res_o.flags.at == cbl_at_e'($past(f_bo[1:0])))
		else $error("at hint decoded wrongly");

	ack_single_a: assert property (
		bus_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Bus acknowledge not a single cycle");

	false_only_a: assert property (
		go && f_bo[4:2] == 3'h1 |=> res_o.flags.taken == !$past(cr_bit))
		else $error("False-condition branch decided wrongly");

	true_only_a: assert property (
		go && f_bo[4:2] == 3'h3 |=> res_o.flags.taken == $past(cr_bit))
		else $error("True-condition branch decided wrongly");

	count_zero_false_a: assert property (
		go && f_bo[4:1] == 4'h1
		|=> res_o.flags.taken == ($past(st_q.ctr) == 32'h0000_0001 && !$past(cr_bit)))
		else $error("Count-zero false branch decided wrongly");

	count_nonzero_true_a: assert property (
		go && f_bo[4:1] == 4'h4
		|=> res_o.flags.taken == ($past(st_q.ctr) != 32'h0000_0001 && $past(cr_bit)))
		else $error("Count-nonzero true branch decided wrongly");

	count_only_a: assert property (
		go && f_bo[4] && !f_bo[2]
		|=> res_o.flags.taken == (($past(st_q.ctr) == 32'h0000_0001) == $past(f_bo[BO_ZERO])))
		else $error("Count-only branch decided wrongly");

	always_branch_a: assert property (
		go && f_bo[4] && f_bo[2] |=> res_o.flags.taken)
		else $error("Unconditional form not taken");

	decr_flag_a: assert property (
		go && !f_bo[BO_NODEC] |=> res_o.flags.decr)
		else $error("Decrement not reported");

	invalid_no_effect_a: assert property (
		hit && bad && !bus_wr |=> !res_o.flags.taken && $stable(st_q.lr) && $stable(st_q.ctr))
		else $error("Invalid form changed state or branched");

	y_hint_a: assert property (
		hit && !is_v2(st_q.mode) |=> res_o.flags.y_hint == $past(f_bo[BO_HINT]))
		else $error("y hint not passed on");

	count_form_hint_a: assert property (
		hit && is_v2(st_q.mode) && f_bo[4] && !f_bo[2]
		|=> res_o.flags.at == cbl_at_e'({$past(f_bo[BO_SENSE]), $past(f_bo[BO_HINT])}))
		else $error("at hint of a count form decoded wrongly");

	usage_hint_a: assert property (
		hit |=> res_o.flags.bh == cbl_bh_e'($past(f_bh)))
		else $error("Usage hint decoded wrongly");

	foreign_word_a: assert property (
		fetch_i.valid && !hit && !bus_wr
		|=> res_o.flags.unrec && $stable(st_q.lr) && $stable(st_q.ctr))
		else $error("Foreign word acted on");

	old_link_target_a: assert property (
		go && f_lk |=> res_o.target == {$past(st_q.lr[31:2]), 2'b00} && res_o.flags.linked)
		else $error("Linking branch target not from old link value");

	next_address_a: assert property (
		hit |=> res_o.next == (res_o.flags.taken ? res_o.target
			: $past(fetch_i.cia) + CBL_INSN_BYTES))
		else $error("Next address wrong");

	result_pulse_a: assert property (
		!fetch_i.valid |=> !res_o.flags.valid)
		else $error("Result valid without an offer");

	ack_on_request_a: assert property (
		!bus_req |=> !wb_ack_o)
		else $error("Acknowledge without a request");

	ctr_write_a: assert property (
		bus_wr && wb_i.adr == ADDR_CTR && wb_i.sel == 4'hF && !fetch_i.valid
		|=> st_q.ctr == $past(wb_i.dat))
		else $error("Loop count write lost");

	mode_write_a: assert property (
		bus_wr && wb_i.adr == ADDR_MODE && wb_i.sel[0]
		|=> st_q.mode == cbl_mode_e'($past(wb_i.dat[1:0])))
		else $error("Mode write lost");

	unmapped_read_a: assert property (
		bus_req && !wb_i.we && wb_i.adr > ADDR_NEXT |=> wb_dat_o == 32'h0000_0000)
		else $error("Unmapped read not zero");

	lr_read_a: assert property (
		bus_req && !wb_i.we && wb_i.adr == ADDR_LR |=> wb_dat_o == $past(st_q.lr))
		else $error("Link register read wrong");

	linked_taken_c: cover property (go && f_lk ##1 res_o.flags.taken);
	invalid_seen_c: cover property (res_o.flags.invalid);
	always_taken_c: cover property (go && f_bo == 5'h14 ##1 res_o.flags.taken);
	bus_read_c: cover property (bus_req && !wb_i.we ##1 wb_ack_o);
	classic_invalid_c: cover property (hit && st_q.mode == CBL_MODE_CLASSIC ##1 res_o.flags.invalid);
endmodule

/* File: dv/cbl_fetch_model.sv */
// Instruction fetch and sequencing model that offers words to the executor
module cbl_fetch_model
	import cbl_pkg::*;
(
	input  wire logic clk_i,   // Core clock
	output cbl_fetch_s fetch_o // Offered instruction
);
	timeunit 1ns;
	timeprecision 1ns;
	initial fetch_o = '0;
	// One word per call; after the taking edge the lines carry junk, not the old word
	task automatic offer(input logic [31:0] w, input logic [31:0] a);
		@(posedge clk_i);
		fetch_o <= '{1'b1, w, a};
		@(posedge clk_i);
		fetch_o <= '{1'b0, ~w, ~a};
	endtask
endmodule

/* File: dv/tb.sv */
// Directed bench for the branch-to-link-register executor
module tb
	import cbl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	cbl_wb_req_s wb = '0;
	cbl_fetch_s  fetch;
	logic        wb_ack_o;
	logic [31:0] wb_dat_o;
	cbl_result_s res_o;
	logic [31:0] lr_o;
	logic [31:0] ctr_o;
	logic [31:0] lr_m;
	logic [31:0] cia = 32'h0000_0100;
	logic [31:0] d;
	int          mismatches = 0;
	int          checked = 0;
	int          cycles = 0;
	always #50 clk_i = ~clk_i;
	cbl_exec cbl_exec_i (.clk_i(clk_i), .rst_i(rst_i), .fetch_i(fetch), .wb_i(wb),
		.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .res_o(res_o), .lr_o(lr_o), .ctr_o(ctr_o));
	cbl_fetch_model cbl_fetch_model_i (.clk_i(clk_i), .fetch_o(fetch));
	task automatic results();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Long enough for every scenario with a wide margin
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	// Hold the request until ack is sampled, then release
	task automatic wb_cyc(input logic we, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		wb <= '{1'b1, 1'b1, we, 4'hF, a, v};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		d = wb_dat_o;
		wb <= '0;
	endtask
	function automatic logic [31:0] mk(logic [4:0] bo, logic [4:0] bi, logic [1:0] bh,
			logic lk);
		return {CBL_PRIMARY_OP, bo, bi, 3'h0, bh, CBL_EXT_OP, lk};
	endfunction
	task automatic run(input logic [31:0] w, input logic [31:0] c0, input logic tk,
			input logic inv);
		logic [31:0] tg;
		logic [31:0] le;
		logic        dec;
		wb_cyc(1'b1, ADDR_CTR, c0);
		tg = {lr_m[31:2], 2'h0};
		le = (w[LK_POS] && !inv) ? cia + CBL_INSN_BYTES : lr_m;
		dec = !w[BO_LSB + BO_NODEC] && !inv;
		cbl_fetch_model_i.offer(w, cia);
		// Result valid stands for one cycle only, right after the taking edge
		#1;
		chk("valid", 32'(res_o.flags.valid), 32'h0000_0001);
		chk("taken", 32'(res_o.flags.taken), 32'(tk));
		chk("invalid", 32'(res_o.flags.invalid), 32'(inv));
		chk("target", res_o.target, tg);
		chk("next", res_o.next, tk ? tg : cia + CBL_INSN_BYTES);
		chk("lr", lr_o, le);
		chk("ctr", ctr_o, c0 - 32'(dec));
		chk("decr", 32'(res_o.flags.decr), 32'(dec));
		chk("linked", 32'(res_o.flags.linked), 32'(w[LK_POS] && !inv));
		chk("bh", 32'(res_o.flags.bh), 32'(w[BH_LSB +: 2]));
		lr_m = le;
		cia = cia + 32'h0000_0010;
	endtask
	task automatic t_reset();
		wb_cyc(1'b0, ADDR_MODE, 32'h0000_0000);
		chk("mode", d, 32'h0000_0002);
		wb_cyc(1'b0, ADDR_LR, 32'h0000_0000);
		chk("lr rst", d, 32'h0000_0000);
		wb_cyc(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped", d, 32'h0000_0000);
	endtask
	task automatic t_opts();
		run(mk(5'h00, 5'h01, 2'h0, 1'b0), 32'h0000_0003, 1'b1, 1'b0);
		run(mk(5'h00, 5'h00, 2'h1, 1'b0), 32'h0000_0003, 1'b0, 1'b0);
		run(mk(5'h02, 5'h01, 2'h2, 1'b0), 32'h0000_0001, 1'b1, 1'b0);
		run(mk(5'h02, 5'h01, 2'h3, 1'b0), 32'h0000_0002, 1'b0, 1'b0);
		run(mk(5'h04, 5'h01, 2'h0, 1'b1), 32'h0000_0005, 1'b1, 1'b0);
		run(mk(5'h04, 5'h00, 2'h0, 1'b0), 32'h0000_0005, 1'b0, 1'b0);
		run(mk(5'h08, 5'h00, 2'h0, 1'b0), 32'h0000_0002, 1'b1, 1'b0);
		run(mk(5'h08, 5'h00, 2'h0, 1'b0), 32'h0000_0001, 1'b0, 1'b0);
		run(mk(5'h0A, 5'h1F, 2'h0, 1'b1), 32'h0000_0001, 1'b1, 1'b0);
		run(mk(5'h0A, 5'h01, 2'h0, 1'b0), 32'h0000_0001, 1'b0, 1'b0);
		run(mk(5'h0C, 5'h01, 2'h0, 1'b0), 32'h0000_0007, 1'b0, 1'b0);
		run(mk(5'h10, 5'h01, 2'h0, 1'b0), 32'h0000_0002, 1'b1, 1'b0);
		run(mk(5'h12, 5'h00, 2'h0, 1'b0), 32'h0000_0002, 1'b0, 1'b0);
		run(mk(5'h14, 5'h01, 2'h0, 1'b1), 32'h0000_0000, 1'b1, 1'b0);
		run(mk(5'h01, 5'h01, 2'h0, 1'b1), 32'h0000_0003, 1'b0, 1'b1);
		run(mk(5'h15, 5'h01, 2'h0, 1'b1), 32'h0000_0003, 1'b0, 1'b1);
	endtask
	task automatic t_hints();
		for (int i = 0; i < 4; i++) begin
			run(mk(5'h0C | 5'(i), 5'h00, 2'(i), 1'b0), 32'h0000_0001, 1'b1, 1'b0);
			chk("at", 32'(res_o.flags.at), 32'(i));
		end
		wb_cyc(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk("status", d, 32'h0000_0782);
		wb_cyc(1'b0, ADDR_TARGET, 32'h0000_0000);
		chk("target reg", d, {lr_m[31:2], 2'h0});
		wb_cyc(1'b0, ADDR_NEXT, 32'h0000_0000);
		chk("next reg", d, {lr_m[31:2], 2'h0});
		wb_cyc(1'b1, ADDR_MODE, 32'(CBL_MODE_LEGACY));
		run(mk(5'h07, 5'h01, 2'h0, 1'b0), 32'h0000_0004, 1'b1, 1'b0);
		chk("y", 32'(res_o.flags.y_hint), 32'h0000_0001);
		run(mk(5'h1F, 5'h01, 2'h0, 1'b0), 32'h0000_0004, 1'b1, 1'b0);
		wb_cyc(1'b1, ADDR_MODE, 32'(CBL_MODE_CLASSIC));
		run(mk(5'h06, 5'h01, 2'h0, 1'b0), 32'h0000_0003, 1'b0, 1'b1);
		run(mk(5'h01, 5'h01, 2'h0, 1'b0), 32'h0000_0003, 1'b1, 1'b0);
		chk("y classic", 32'(res_o.flags.y_hint), 32'h0000_0001);
		wb_cyc(1'b1, ADDR_MODE, 32'h0000_0003);
		run(mk(5'h0F, 5'h00, 2'h0, 1'b0), 32'h0000_0001, 1'b1, 1'b0);
		chk("at mode3", 32'(res_o.flags.at), 32'h0000_0003);
	endtask
	task automatic t_unrec();
		logic [31:0] w;
		w = mk(5'h14, 5'h00, 2'h0, 1'b1);
		w[XO_LSB +: 10] = 10'h210;
		cbl_fetch_model_i.offer(w, cia);
		#1;
		chk("unrec", 32'(res_o.flags.unrec), 32'h0000_0001);
		chk("lr kept", lr_o, lr_m);
		wb_cyc(1'b0, ADDR_CR, 32'h0000_0000);
		chk("cr kept", d, 32'h8000_0001);
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		lr_m = 32'h0000_1237;
		wb_cyc(1'b1, ADDR_LR, lr_m);
		wb_cyc(1'b1, ADDR_CR, 32'h8000_0001);
		t_opts();
		t_hints();
		t_unrec();
		results();
	end
endmodule
